// ### hw/afe_timing_pkg.sv
// constants shared by the command and second-LED timing register bank
package afe_timing_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] CMD_ADDR          = 8'h00;
  localparam logic [7:0] SAMPLE_START_ADDR = 8'h01;
  localparam logic [7:0] SAMPLE_END_ADDR   = 8'h02;
  localparam logic [7:0] DRIVE_START_ADDR  = 8'h03;
  localparam logic [7:0] DIAGNOSTIC_FLAGS_FLAGS_ADDR   = 8'h30;

  // ****************************************
  // command register fields
  // ****************************************
  localparam int SOFT_RESET_BIT = 3;
  localparam int DIAGNOSTIC_FLAGS_RUN_BIT   = 2;
  localparam int HOLD_BIT       = 1;
  localparam int READBACK_BIT   = 0;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int ADDR_WIDTH  = 8;
  localparam int DATA_WIDTH  = 24;
  localparam int COUNT_WIDTH = 16;
  localparam int FLAGS_WIDTH = 13;
  localparam int FRAME_BITS  = ADDR_WIDTH + DATA_WIDTH;

  localparam logic [DATA_WIDTH-1:0]  CMD_RESET   = 24'h000000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 16'h0000;
  localparam logic [FLAGS_WIDTH-1:0] FLAGS_RESET = 13'h0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLOCK_PERIOD_NS   = 8;
  localparam int TIMER_TICK_NS     = 250;
  localparam int TIMER_TICK_CYCLES = TIMER_TICK_NS / CLOCK_PERIOD_NS;
  localparam int DIAGNOSTIC_FLAGS_TIME_MS      = 16;
  localparam int DIAGNOSTIC_FLAGS_CYCLES       =
    DIAGNOSTIC_FLAGS_TIME_MS * 1000000 / CLOCK_PERIOD_NS;

endpackage

// ### hw/afe_timing_regs.sv
// command register, second-LED timing compares and serial register port
`timescale 1ns/1ps

// Summary of operation
// - Command register is write-only, reads as zero and resets to zero.
// - Command bit 3 resets every register to default, then self-clears.
// - Writing one to command bit 2 starts the diagnostic run at once.
// - At run end the fault results are latched and the run bit clears.
// - The diagnostic run lasts 16 ms and then clears itself.
// - Data is flagged invalid during the run and the host discards it.
// - While command bit 1 is one the timing counters are held in reset.
// - Readback is off by default and is enabled by command bit 0.
// - The sample window opens when the timer reaches the start count.
// - Counts are stored as written; none is limited to the period count.
// - The sample window closes when the timer reaches the end count.
// - The LED drive starts when the timer hits the drive-start count.
// - Compare registers clear to zero at power-up and on a soft reset.
module afe_timing_regs #(
  parameter int DIAGNOSTIC_FLAGS_CYCLES = afe_timing_pkg::DIAGNOSTIC_FLAGS_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        ste_n,
  input  wire logic        sdin,
  output logic             sdout,
  input  wire logic [15:0] period_count,
  input  wire logic [12:0] fault_status,
  output logic             adc_data_invalid,
  output logic             sample_window,
  output logic             drive_start_pulse
);

  localparam int AW = afe_timing_pkg::ADDR_WIDTH;
  localparam int DW = afe_timing_pkg::DATA_WIDTH;
  localparam int CW = afe_timing_pkg::COUNT_WIDTH;
  localparam int FW = afe_timing_pkg::FLAGS_WIDTH;
  localparam int FB = afe_timing_pkg::FRAME_BITS;
  localparam int TICKS = afe_timing_pkg::TIMER_TICK_CYCLES;
  localparam logic [20:0] DIAGNOSTIC_FLAGS_LAST = 21'(DIAGNOSTIC_FLAGS_CYCLES - 1);
  localparam logic [4:0]  TICK_LAST = 5'(TICKS - 1);
  localparam logic [5:0]  ADDR_DONE = 6'(AW - 1);
  localparam logic [5:0]  FRAME_DONE = 6'(FB - 1);
  localparam logic [5:0]  FRAME_END = 6'(FB);
  localparam logic [5:0]  DATA_FIRST = 6'(AW);

  generate
    if (DIAGNOSTIC_FLAGS_CYCLES < 2 || DIAGNOSTIC_FLAGS_CYCLES > 2097151 || TICKS < 1 || TICKS > 32)
    begin : g_bad_param
      $error("afe_timing_regs parameters out of range");
    end
  endgenerate

  typedef struct packed {
    logic          sclk_prev;
    logic [5:0]    bit_count;
    logic [FB-2:0] shift_in;
    logic [DW-1:0] shift_out;
    logic          sdout;
    logic          hold;
    logic          readback;
    logic          diagnostic_flags_active;
    logic [20:0]   diagnostic_flags_count;
    logic [FW-1:0] diagnostic_flags_flags;
    logic [CW-1:0] sample_start;
    logic [CW-1:0] sample_end;
    logic [CW-1:0] drive_start;
    logic [4:0]    tick_count;
    logic          tick;
    logic [CW-1:0] period_timer;
    logic          sample_window;
    logic          drive_start_pulse;
  } state_type;

  state_type     cur;
  state_type     next_state;
  logic          start_hit;
  logic          end_hit;
  logic          drive_hit;
  logic          load_event;
  logic          commit;
  logic          soft_reset;
  logic [AW-1:0] read_addr;
  logic [FB-1:0] frame;

  // ****************************************
  // compares
  // ****************************************
  period_compare #(.WIDTH(CW)) u_start_cmp (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (cur.tick),
    .timer (cur.period_timer),
    .count (cur.sample_start),
    .hit   (start_hit)
  );

  period_compare #(.WIDTH(CW)) u_end_cmp (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (cur.tick),
    .timer (cur.period_timer),
    .count (cur.sample_end),
    .hit   (end_hit)
  );

  period_compare #(.WIDTH(CW)) u_drive_cmp (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (cur.tick),
    .timer (cur.period_timer),
    .count (cur.drive_start),
    .hit   (drive_hit)
  );

  function automatic logic [DW-1:0] read_value(input logic [AW-1:0] addr,
                                               input state_type s);
    logic [DW-1:0] v;
    v = '0;
    unique case (addr)
      afe_timing_pkg::SAMPLE_START_ADDR: v = {8'h00, s.sample_start};
      afe_timing_pkg::SAMPLE_END_ADDR:   v = {8'h00, s.sample_end};
      afe_timing_pkg::DRIVE_START_ADDR:  v = {8'h00, s.drive_start};
      afe_timing_pkg::DIAGNOSTIC_FLAGS_FLAGS_ADDR:   v = {11'h000, s.diagnostic_flags_flags};
      // command register is write-only and reads as zero
      default: v = afe_timing_pkg::CMD_RESET;
    endcase
    return v;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = cur;
    load_event = 1'b0;
    commit     = 1'b0;
    soft_reset = 1'b0;
    read_addr  = {cur.shift_in[AW-2:0], sdin};
    frame      = {cur.shift_in, sdin};
    next_state.sclk_prev = sclk;

    // serial port: sample on rising sclk, shift out on falling sclk
    if (ste_n) begin
      next_state.bit_count = '0;
      next_state.sdout     = 1'b0;
    end else if (sclk && !cur.sclk_prev && cur.bit_count < FRAME_END) begin
      next_state.shift_in  = frame[FB-2:0];
      next_state.bit_count = cur.bit_count + 6'h01;
      if (cur.bit_count == ADDR_DONE) begin
        load_event = 1'b1;
        // data is shifted out as zero until readback is allowed
        next_state.shift_out = cur.readback ?
          read_value(read_addr, cur) : '0;
      end
      if (cur.bit_count == FRAME_DONE) begin
        commit = 1'b1;
      end
    end else if (!sclk && cur.sclk_prev && cur.bit_count >= DATA_FIRST &&
                 cur.bit_count < FRAME_END) begin
      next_state.sdout     = cur.shift_out[DW-1];
      next_state.shift_out = {cur.shift_out[DW-2:0], 1'b0};
    end

    // diagnostic run
    if (cur.diagnostic_flags_active) begin
      if (cur.diagnostic_flags_count == DIAGNOSTIC_FLAGS_LAST) begin
        next_state.diagnostic_flags_active = 1'b0;
        next_state.diagnostic_flags_count  = '0;
        next_state.diagnostic_flags_flags  = fault_status;
      end else begin
        next_state.diagnostic_flags_count = cur.diagnostic_flags_count + 21'h000001;
      end
    end

    // register writes; upper command bits are simply not looked at
    if (commit) begin
      if (frame[FB-1:DW] == afe_timing_pkg::CMD_ADDR) begin
        if (frame[afe_timing_pkg::SOFT_RESET_BIT]) begin
          soft_reset = 1'b1;
        end else begin
          next_state.hold = frame[afe_timing_pkg::HOLD_BIT];
          next_state.readback = frame[afe_timing_pkg::READBACK_BIT];
          if (frame[afe_timing_pkg::DIAGNOSTIC_FLAGS_RUN_BIT] && !cur.diagnostic_flags_active) begin
            next_state.diagnostic_flags_active = 1'b1;
            next_state.diagnostic_flags_count  = '0;
          end
        end
      end else if (!cur.readback) begin
        // while readback is on, frames to other registers are reads
        unique case (frame[FB-1:DW])
          afe_timing_pkg::SAMPLE_START_ADDR:
            next_state.sample_start = frame[CW-1:0];
          afe_timing_pkg::SAMPLE_END_ADDR:
            next_state.sample_end = frame[CW-1:0];
          afe_timing_pkg::DRIVE_START_ADDR:
            next_state.drive_start = frame[CW-1:0];
          default: next_state.hold = cur.hold;
        endcase
      end
    end

    // timer tick and period timer
    if (cur.tick_count == TICK_LAST) begin
      next_state.tick_count = '0;
      next_state.tick       = 1'b1;
    end else begin
      next_state.tick_count = cur.tick_count + 5'h01;
      next_state.tick       = 1'b0;
    end
    if (cur.hold) begin
      next_state.period_timer = '0;
      next_state.tick_count   = '0;
      next_state.tick         = 1'b0;
    end else if (cur.tick) begin
      // wrap at the programmed period length
      if (cur.period_timer == period_count) begin
        next_state.period_timer = '0;
      end else begin
        next_state.period_timer = cur.period_timer + 16'h0001;
      end
    end

    // start wins when start and end counts coincide
    if (start_hit) begin
      next_state.sample_window = 1'b1;
    end else if (end_hit) begin
      next_state.sample_window = 1'b0;
    end
    next_state.drive_start_pulse = drive_hit;

    if (soft_reset) begin
      next_state.hold          = 1'b0;
      next_state.readback      = 1'b0;
      next_state.diagnostic_flags_active   = 1'b0;
      next_state.diagnostic_flags_count    = '0;
      next_state.diagnostic_flags_flags    = afe_timing_pkg::FLAGS_RESET;
      next_state.sample_start  = afe_timing_pkg::COUNT_RESET;
      next_state.sample_end    = afe_timing_pkg::COUNT_RESET;
      next_state.drive_start   = afe_timing_pkg::COUNT_RESET;
      next_state.period_timer  = '0;
      next_state.tick_count    = '0;
      next_state.tick          = 1'b0;
      next_state.sample_window = 1'b0;
    end
  end

  // all reset values are zero, matching the register defaults
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_state;
    end
  end

  assign sdout             = cur.sdout;
  assign adc_data_invalid  = cur.diagnostic_flags_active;
  assign sample_window     = cur.sample_window;
  assign drive_start_pulse = cur.drive_start_pulse;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_CMD_READS_ZERO: assert property (
    load_event && read_addr == afe_timing_pkg::CMD_ADDR |=> cur.shift_out == '0
  ) else $error("command register did not read as zero");

  AST_SOFT_RESET: assert property (
    soft_reset |=> !cur.hold && !cur.readback && !cur.diagnostic_flags_active &&
      cur.sample_start == '0 && cur.sample_end == '0 && cur.drive_start == '0
  ) else $error("software reset left a register set");

  AST_DIAGNOSTIC_FLAGS_START: assert property (
    commit && frame[FB-1:DW] == afe_timing_pkg::CMD_ADDR &&
    frame[afe_timing_pkg::DIAGNOSTIC_FLAGS_RUN_BIT] && !cur.diagnostic_flags_active &&
    !frame[afe_timing_pkg::SOFT_RESET_BIT] |=> adc_data_invalid
  ) else $error("diagnostic run did not start");

  AST_DIAGNOSTIC_FLAGS_LATCH: assert property (
    cur.diagnostic_flags_active && cur.diagnostic_flags_count == DIAGNOSTIC_FLAGS_LAST && !soft_reset
    |=> !cur.diagnostic_flags_active && cur.diagnostic_flags_flags == $past(fault_status)
  ) else $error("fault results not latched at end of run");

  AST_DIAGNOSTIC_FLAGS_BOUND: assert property (
    cur.diagnostic_flags_active |-> cur.diagnostic_flags_count <= DIAGNOSTIC_FLAGS_LAST
  ) else $error("diagnostic run overran its length");

  AST_HOLD_TIMER: assert property (
    cur.hold |=> cur.period_timer == '0
  ) else $error("period timer ran while held");

  AST_READBACK_OFF: assert property (
    load_event && !cur.readback |=> cur.shift_out == '0
  ) else $error("data shifted out while readback is off");

  AST_WINDOW_START: assert property (
    cur.tick && cur.period_timer == cur.sample_start && !soft_reset
    |-> ##2 (sample_window || $past(soft_reset))
  ) else $error("sample window did not open on its count");

  AST_WINDOW_END: assert property (
    cur.tick && cur.period_timer == cur.sample_end &&
    cur.sample_end != cur.sample_start |-> ##2 !sample_window
  ) else $error("sample window did not close on its count");

  AST_DRIVE_START: assert property (
    cur.tick && cur.period_timer == cur.drive_start |-> ##2 drive_start_pulse
  ) else $error("drive start pulse missing");

  COV_DIAGNOSTIC_FLAGS_DONE: cover property ($fell(adc_data_invalid));
  COV_WINDOW: cover property (
    $rose(sample_window) ##[1:300] $fell(sample_window));
  COV_DRIVE: cover property (drive_start_pulse);
  COV_READ: cover property (load_event && cur.readback);

endmodule

// ### hw/period_compare.sv
// one equality compare of the period timer against a programmed count
`timescale 1ns/1ps

module period_compare #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] timer,
  input  wire logic [WIDTH-1:0] count,
  output logic                  hit
);

  typedef struct packed {
    logic hit;
  } state_type;

  state_type cur;
  state_type next_state;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("period_compare width must be positive");
    end
  endgenerate

  always_comb begin
    next_state     = cur;
    next_state.hit = tick && (timer == count);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_state;
    end
  end

  assign hit = cur.hit;

  // ****************************************
  // checks
  // ****************************************
  AST_COMPARE_HIT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (tick && timer == count) |=> hit
  ) else $error("equal count on a tick gave no hit");

  AST_COMPARE_ONLY_ON_TICK: assert property (
    @(posedge clock) disable iff (!rst_n)
    !tick |=> !hit
  ) else $error("hit without a timer tick");

endmodule

// ### sim/spi_host.sv
// serial host model that frames register reads and writes
`timescale 1ns/1ps

module spi_host (
  input  wire logic        clock,
  output logic             sclk,
  output logic             ste_n,
  output logic             sdin,
  input  wire logic        sdout,
  output logic             rd_done,
  output logic [23:0]      rd_data
);
  initial begin
    sclk = 1'b0;
    ste_n = 1'b1;
    sdin = 1'b0;
    rd_done = 1'b0;
    rd_data = 24'h000000;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // ****************************************
  // one 32-bit frame, msb first
  // ****************************************
  // clock stands low outside frames; data idles at the inverse of the last bit sent
  task automatic xfer(input logic [31:0] w, input logic rd);
    logic [23:0] d;
    step(1);
    ste_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdin = w[i];
      step(3);
      if (i < 24) begin
        d[i] = sdout;
      end
      sclk = 1'b1;
      step(3);
      sclk = 1'b0;
    end
    step(3);
    ste_n = 1'b1;
    sdin = ~sdin;
    if (rd) begin
      rd_data = d;
      rd_done = 1'b1;
      step(1);
      rd_done = 1'b0;
    end
    step(1);
  endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the command and second-led timing registers
`timescale 1ns/1ps

module tb;
  localparam int DIAGC = 50;
  localparam int PER = 9;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  wire         sclk;
  wire         ste_n;
  wire         sdin;
  logic        sdout;
  logic [15:0] period_count = 16'h0009;
  logic [12:0] fault_status = 13'h0000;
  logic        adc_data_invalid;
  logic        sample_window;
  logic        drive_start_pulse;
  wire         rd_done;
  wire  [23:0] rd_data;
  logic [23:0] expq[$];
  logic [15:0] v1, v2, v3;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0, dcnt = 0, wcnt = 0, last = 0, npulse = 0, n0;
  int exp_win = 0;
  int n_win = 0;
  int n_diagnostic_flags = 0;
  logic chk_win = 1'b0;
  logic chk_gap = 1'b0;

  always #4 clock = ~clock;

  afe_timing_regs #(.DIAGNOSTIC_FLAGS_CYCLES(DIAGC)) i_afe_timing_regs (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .ste_n(ste_n),
    .sdin(sdin), .sdout(sdout), .period_count(period_count),
    .fault_status(fault_status), .adc_data_invalid(adc_data_invalid),
    .sample_window(sample_window), .drive_start_pulse(drive_start_pulse)
  );

  spi_host i_spi_host (
    .clock(clock), .sclk(sclk), .ste_n(ste_n), .sdin(sdin),
    .sdout(sdout), .rd_done(rd_done), .rd_data(rd_data)
  );

  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk24(input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chkn(input int e, input int g);
    comparisons++;
    if (g != e) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // upper byte always sent as zero
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    i_spi_host.xfer({a, 8'h00, v}, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    expq.push_back(e);
    i_spi_host.xfer({a, 24'h000000}, 1'b1);
  endtask

  // ****************************************
  // output monitor
  // ****************************************
  always @(posedge clock) begin
    cyc++;
    if (rd_done && expq.size() > 0) begin
      chk24(expq.pop_front(), rd_data);
    end
    if (adc_data_invalid) begin
      dcnt++;
    end else if (dcnt != 0) begin
      chkn(DIAGC, dcnt);
      dcnt = 0;
      n_diagnostic_flags++;
    end
    if (sample_window) begin
      wcnt++;
    end else if (wcnt != 0) begin
      if (chk_win) begin
        chkn(exp_win, wcnt);
        n_win++;
      end
      wcnt = 0;
    end
    if (drive_start_pulse) begin
      if (chk_gap && last != 0) begin
        chkn((PER + 1) * 31, cyc - last);
      end
      last = cyc;
      npulse++;
    end
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    test_done;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h94f1));
    step(8);
    rst_n = 1'b1;
    v1 = 16'(1 + $urandom % 4);
    v2 = v1 + 16'(1 + $urandom % 4);
    v3 = 16'($urandom % 10);
    exp_win = (v2 - v1) * 31;
    wr(8'h01, v1);
    wr(8'h02, v2);
    wr(8'h03, v3);
    // readback off: the frame rewrites v1 and must shift out zeros
    expq.push_back(24'h000000);
    i_spi_host.xfer({8'h01, 8'h00, v1}, 1'b1);
    wr(8'h00, 16'hfff1);
    rd(8'h01, {8'h00, v1});
    rd(8'h02, {8'h00, v2});
    rd(8'h03, {8'h00, v3});
    rd(8'h10, 24'h000000);
    // a command frame also writes, so readback ends here
    rd(8'h00, 24'h000000);
    while (sample_window) step(1);
    chk_win = 1'b1;
    chk_gap = 1'b1;
    n0 = npulse;
    step(1300);
    chkn(1, int'(n_win >= 3));
    chkn(1, int'(npulse - n0 >= 4));
    chk_win = 1'b0;
    // timer frozen: no events may appear
    chk_gap = 1'b0;
    wr(8'h00, 16'h0002);
    n0 = npulse;
    step(400);
    chkn(n0, npulse);
    wr(8'h00, 16'h0000);
    last = 0;
    chk_gap = 1'b1;
    step(700);
    chk_gap = 1'b0;
    fault_status = 13'($urandom);
    wr(8'h00, 16'h0004);
    step(DIAGC + 10);
    chkn(1, n_diagnostic_flags);
    wr(8'h00, 16'h0001);
    rd(8'h30, {11'h000, fault_status});
    wr(8'h00, 16'h0008);
    wr(8'h00, 16'h0001);
    rd(8'h01, 24'h000000);
    rd(8'h02, 24'h000000);
    rd(8'h03, 24'h000000);
    step(5);
    test_done;
  end
endmodule
